/* core/cgpc_regs.svh */
// Timing counts and factory configuration constants for the clock control core
`ifndef CGPC_REGS_SVH
`define CGPC_REGS_SVH
// Clock rate and pulse qualification
`define CGPC_CLK_MHZ          125
`define CGPC_MIN_PULSE_NS     100
// Least time rounds up: 100 ns at 8 ns period gives 13 cycles
`define CGPC_MIN_PULSE_CYC    ((`CGPC_MIN_PULSE_NS * `CGPC_CLK_MHZ + 999) / 1000)
`define CGPC_MAX_RATE_KHZ     1500
// Least spacing rounds up so the rate never tops 1.5 MHz: 84 cycles
`define CGPC_STEP_GAP_CYC     ((`CGPC_CLK_MHZ*1000 + `CGPC_MAX_RATE_KHZ - 1) / `CGPC_MAX_RATE_KHZ)
// Phase range: +-45 ns in 20 ps units
`define CGPC_PHASE_RES_PS     20
`define CGPC_PHASE_RANGE_PS   45000
`define CGPC_PHASE_LIMIT      (`CGPC_PHASE_RANGE_PS / `CGPC_PHASE_RES_PS)
// Outputs stopped after an illegal step, in cycles
`define CGPC_STALL_CYC        10
// Loss of lock threshold
`define CGPC_LOL_PPM          1000
// Self-calibration duration in cycles
`define CGPC_CAL_CYC          64
// Factory configuration (fixed, no runtime path)
`define CGPC_OUT_EN           4'hf
`define CGPC_PH_EN            4'h3
`define CGPC_PH_STEP          12'h005
`define CGPC_SS_EN            4'h0
`define CGPC_FREQ_STEP        24'h000010
`define CGPC_FREQ_INIT        24'h100000
`define CGPC_FREQ_MIN         24'h010000
`define CGPC_FREQ_MAX         24'h800000
`define CGPC_FREQ_LOW         24'h020000
`define CGPC_MUX0             4'h1
`define CGPC_SS_DEPTH         24'h000200
`endif

/* core/cgpc_pkg.sv */
// Types shared by the clock control core
package cgpc_pkg;
  typedef logic signed [12:0] cgpc_phase_t;
  typedef enum logic [1:0] {
    CGPC_CAL  = 2'b00,
    CGPC_RUN  = 2'b01,
    CGPC_STOP = 2'b10
  } cgpc_state_e;
  typedef struct packed {
    logic        lock_lost;
    logic        input_lost;
  } cgpc_alarm_s;
endpackage : cgpc_pkg

/* core/cgpc_clock_gen_pin_control.sv */
// Pin-controlled control logic of a four-output clock generator
// Behaviour
// - output_disable_n high stops all enabled outputs low; low lets them run.
// - Initial phase offset applies only where output_post_divider equals one.
// - One shared inc and dec pin; per-channel enable, one shared step magnitude.
// - Phase accumulator clamps to +-45 ns in 20 ps units, updated glitchlessly.
// - No phase stepping on channels with spread enabled.
// - Steps accepted no faster than 1.5 MHz, only on outputs under Fvco/8.
// - Step enables and magnitudes are fixed factory constants.
// - Decrement making period under 8/Fvco stops outputs ten periods, phase kept.
// - Frequency stepping acts only on divider 0, muxed to any outputs.
// - Frequency step is a factory constant within 5 MHz to Fvco/8.
// - Increment above Fvco/8 stops outputs ten cycles, frequency kept.
// - Frequency changes glitchless, requests at most 1.5 MHz.
// - Spread and frequency stepping never active on the same output.
// - Below 5 MHz the post divider engages with ratio 1,2,4,8,16,32.
// - Effective step at an output is divider 0 step over its ratio.
// - Non-unity post divider drops the initial phase guarantee.
// - spread_disable_n low gives 0.5% down-spread triangle on enabled outputs.
// - No logic reset beyond power-on; i_nrst models power application.
// - lock_signal_alarm asserts on loss_of_lock or loss_of_input.
// - Lock lost over 1000 ppm difference; regained once the difference is back at 1000 ppm or under.
// - Calibration masks loss_of_lock; outputs enabled only after it finishes.
// - Pin 3 pulse increments, pin 4 pulse decrements by factory amount.
`include "cgpc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module cgpc_clock_gen_pin_control (
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_output_disable_n,
  input  wire logic        i_spread_disable_n,
  input  wire logic        i_step_up,
  input  wire logic        i_step_down,
  input  wire logic        i_input_present,
  input  wire logic [10:0] i_pfd_ppm_diff,
  input  wire logic        i_vco_fast_limit,
  input  wire logic [3:0]  i_phase_too_short,
  output logic [3:0]       o_clk_run,
  output logic [3:0]       o_phase_step_apply,
  output cgpc_pkg::cgpc_phase_t o_phase0,
  output cgpc_pkg::cgpc_phase_t o_phase1,
  output cgpc_pkg::cgpc_phase_t o_phase2,
  output cgpc_pkg::cgpc_phase_t o_phase3,
  output logic [23:0]      o_freq0,
  output logic [2:0]       o_post_div_log2,
  output logic [3:0]       o_spread_on,
  output logic [23:0]      o_spread_offset,
  output logic             o_vco_cal_ctrl,
  output logic             o_lock_signal_alarm
);
  // ==========================================================
  // Reset release and pin synchronisers
  // ==========================================================
  logic       rst_s1_q, rst_n_q;
  logic [4:0] sync1_q, sync2_q;
  // Reset asserts at once, releases through two flops
  // Only this block sees the pin; every other register uses the copy
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end
  // Two-flop synchronisers for every asynchronous pin
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      // Idle levels: input present, step pins low, outputs off, spread off
      sync1_q <= 5'h13;
      sync2_q <= 5'h13;
    end else begin
      sync1_q <= {i_input_present, i_step_down, i_step_up, i_spread_disable_n,
                  i_output_disable_n};
      sync2_q <= sync1_q;
    end
  end
  // Only the second flop of each synchroniser is read past here
  logic oe_dis, ss_dis_n, up_s, dn_s, in_ok;
  assign {in_ok, dn_s, up_s, ss_dis_n, oe_dis} = sync2_q;

  // ==========================================================
  // Pulse qualification: high over 100 ns, then low over 100 ns
  // ==========================================================
  logic [1:0] pulse_ok;
  logic [7:0] hi_cnt_q [2];
  logic [7:0] lo_cnt_q [2];
  logic [1:0] armed_q;
  logic [1:0] pin_lvl;
  assign pin_lvl = {dn_s, up_s};
  // Glitches shorter than the minimum never arm a step
  // Counters saturate, so a pin stuck at one level never wraps into a step
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < 2; i++) begin
        hi_cnt_q[i] <= 8'h00;
        lo_cnt_q[i] <= 8'h00;
      end
      armed_q <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (pin_lvl[i]) begin
          lo_cnt_q[i] <= 8'h00;
          if (hi_cnt_q[i] != 8'hff) hi_cnt_q[i] <= hi_cnt_q[i] + 8'h01;
          if (hi_cnt_q[i] >= 8'(`CGPC_MIN_PULSE_CYC)) armed_q[i] <= 1'b1;
        end else begin
          hi_cnt_q[i] <= 8'h00;
          if (lo_cnt_q[i] != 8'hff) lo_cnt_q[i] <= lo_cnt_q[i] + 8'h01;
          if (pulse_ok[i]) armed_q[i] <= 1'b0;
        end
      end
    end
  end
  // A step is counted once the following low has lasted long enough
  // Pins are synchronised first, so counts lag the pin by two cycles
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pulse_ok[i] = armed_q[i] && !pin_lvl[i] &&
                    (lo_cnt_q[i] >= 8'(`CGPC_MIN_PULSE_CYC));
    end
  end

  // ==========================================================
  // Rate limit and sequencing state
  // ==========================================================
  // Steps are only taken in RUN; calibration and stop refuse them
  cgpc_pkg::cgpc_state_e state_q;
  logic [7:0]  gap_q;
  logic [7:0]  cal_q;
  logic [3:0]  stall_q;
  logic        rate_ok, step_up, step_dn, freq_bad, phase_bad;
  // Requests closer than 1.5 MHz spacing are dropped, not queued
  assign rate_ok = (gap_q == 8'h00) && (state_q == cgpc_pkg::CGPC_RUN);
  assign step_up = pulse_ok[0] && rate_ok;
  // Up wins when both qualify in one cycle; the down request is lost
  assign step_dn = pulse_ok[1] && rate_ok && !step_up;

  // Spacing counter between accepted steps
  // A refused illegal step restarts it too, so the pace stays bounded
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) gap_q <= 8'h00;
    else if (step_up || step_dn) gap_q <= 8'(`CGPC_STEP_GAP_CYC - 1);
    else if (gap_q != 8'h00) gap_q <= gap_q - 8'h01;
  end

  // ==========================================================
  // Frequency stepping on divider 0
  // ==========================================================
  logic [23:0] freq_q, freq_next;
  logic        fstep_allowed;
  // Stepping is off whenever spread may touch a divider-0 output
  // Factory constants fold this to a fixed level; it costs no logic
  assign fstep_allowed = !(|(`CGPC_MUX0 & `CGPC_SS_EN));
  always_comb begin
    freq_next = freq_q;
    if (step_up) freq_next = freq_q + `CGPC_FREQ_STEP;
    else if (step_dn) freq_next = freq_q - `CGPC_FREQ_STEP;
  end
  // Over Fvco/8 triggers a short stop, then the old value stays
  assign freq_bad = fstep_allowed && step_up &&
                    (i_vco_fast_limit || freq_next > `CGPC_FREQ_MAX);
  // A decrement under the floor is ignored quietly; there is no stall for it
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) freq_q <= `CGPC_FREQ_INIT;
    else if (fstep_allowed && (step_up || step_dn) && !freq_bad &&
             freq_next >= `CGPC_FREQ_MIN)
      freq_q <= freq_next;
  end

  // Post divider engages below 5 MHz; ratio 2^n, n up to 5
  // Limitation: one shared ratio, taken from divider 0 for every channel
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) o_post_div_log2 <= 3'h0;
    else if (freq_q >= `CGPC_FREQ_LOW) o_post_div_log2 <= 3'h0;
    else if ((freq_q << 5) < `CGPC_FREQ_LOW) o_post_div_log2 <= 3'h5;
    else begin
      for (int k = 4; k >= 1; k--) begin
        if ((freq_q << k) >= `CGPC_FREQ_LOW) o_post_div_log2 <= 3'(k);
      end
    end
  end
  // Output frequency seen after the post divider; step scales by ratio
  // Uses last cycle's ratio, so a ratio change shows one cycle late
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) o_freq0 <= 24'h000000;
    else o_freq0 <= freq_q >> o_post_div_log2;
  end

  // ==========================================================
  // Per-channel phase stepping
  // ==========================================================
  cgpc_pkg::cgpc_phase_t phase_q [4];
  logic [3:0] ph_ok;
  // Factory enables only; spread channels and divided channels excluded
  assign ph_ok = `CGPC_PH_EN & ~o_spread_on &
                 {4{o_post_div_log2 == 3'h0}};
  // An illegal decrement blocks every channel, not only the short one
  assign phase_bad = step_dn && |(ph_ok & i_phase_too_short);
  // Clamp tested before the move, so the limit is never crossed
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int c = 0; c < 4; c++) phase_q[c] <= '0;
      o_phase_step_apply <= 4'h0;
    end else begin
      o_phase_step_apply <= 4'h0;
      for (int c = 0; c < 4; c++) begin
        if (ph_ok[c] && step_up &&
            phase_q[c] <= 13'sd2250 - $signed({1'b0, `CGPC_PH_STEP})) begin
          phase_q[c] <= phase_q[c] + $signed({1'b0, `CGPC_PH_STEP});
          o_phase_step_apply[c] <= 1'b1;
        end else if (ph_ok[c] && step_dn && !phase_bad &&
                     phase_q[c] >= -13'sd2250 + $signed({1'b0, `CGPC_PH_STEP})) begin
          phase_q[c] <= phase_q[c] - $signed({1'b0, `CGPC_PH_STEP});
          o_phase_step_apply[c] <= 1'b1;
        end
      end
    end
  end
  assign o_phase0 = phase_q[0];
  assign o_phase1 = phase_q[1];
  assign o_phase2 = phase_q[2];
  assign o_phase3 = phase_q[3];

  // ==========================================================
  // Calibration, stall and output enable sequencing
  // ==========================================================
  // Outputs stay off until calibration ends; stalls last ten cycles
  // Stop counts down ten cycles; the offending frequency or phase keeps its old value, the other still steps
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= cgpc_pkg::CGPC_CAL;
      cal_q   <= 8'h00;
      stall_q <= 4'h0;
    end else begin
      unique case (state_q)
        cgpc_pkg::CGPC_CAL: begin
          cal_q <= cal_q + 8'h01;
          if (cal_q == 8'(`CGPC_CAL_CYC - 1)) state_q <= cgpc_pkg::CGPC_RUN;
        end
        cgpc_pkg::CGPC_RUN: begin
          if (freq_bad || phase_bad) begin
            state_q <= cgpc_pkg::CGPC_STOP;
            stall_q <= 4'(`CGPC_STALL_CYC - 1);
          end
        end
        cgpc_pkg::CGPC_STOP: begin
          if (stall_q == 4'h0) state_q <= cgpc_pkg::CGPC_RUN;
          else stall_q <= stall_q - 4'h1;
        end
        default: state_q <= cgpc_pkg::CGPC_CAL;
      endcase
    end
  end
  assign o_vco_cal_ctrl = (state_q == cgpc_pkg::CGPC_CAL);
  // Disable pin high forces every enabled output low
  // Registered, so pin and state changing together cannot glitch an enable
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) o_clk_run <= 4'h0;
    else o_clk_run <= (oe_dis || state_q != cgpc_pkg::CGPC_RUN) ? 4'h0 : `CGPC_OUT_EN;
  end

  // ==========================================================
  // Spread spectrum triangle (0.5% down, about 31.5 kHz)
  // ==========================================================
  logic [11:0] ss_cnt_q;
  logic        ss_dir_q;
  // Half period 1984 cycles gives a 31.5 kHz triangle at 125 MHz
  // Offset runs whenever spread is allowed; channels not enabled ignore it
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ss_cnt_q    <= 12'h000;
      ss_dir_q    <= 1'b0;
      o_spread_on <= 4'h0;
      o_spread_offset <= 24'h000000;
    end else begin
      o_spread_on <= ss_dis_n ? 4'h0 : `CGPC_SS_EN;
      if (ss_cnt_q == 12'h7bf) begin
        ss_cnt_q <= 12'h000;
        ss_dir_q <= ~ss_dir_q;
      end else ss_cnt_q <= ss_cnt_q + 12'h001;
      o_spread_offset <= ss_dis_n ? 24'h000000 :
        24'((`CGPC_SS_DEPTH * (ss_dir_q ? 24'(12'h7bf - ss_cnt_q) : 24'(ss_cnt_q))) / 24'h7bf);
    end
  end

  // ==========================================================
  // Alarm: loss of lock masked during calibration
  // ==========================================================
  // Loss of input is never masked; only loss of lock waits for calibration
  cgpc_pkg::cgpc_alarm_s alarm;
  assign alarm.input_lost = !in_ok;
  assign alarm.lock_lost  = !o_vco_cal_ctrl &&
                            (i_pfd_ppm_diff > 11'(`CGPC_LOL_PPM));
  // Registered so the pin never shows a combinational glitch
  always_ff @(posedge i_mclk or negedge rst_n_q) begin
    if (!rst_n_q) o_lock_signal_alarm <= 1'b0;
    else o_lock_signal_alarm <= alarm.lock_lost || alarm.input_lost;
  end
endmodule : cgpc_clock_gen_pin_control
`default_nettype wire

/* tb/cgpc_clock_gen_pin_control_asserts.sv */
// Port-level checker for the clock control core
`include "cgpc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module cgpc_clock_gen_pin_control_asserts (
  input wire logic                  i_mclk,
  input wire logic                  i_nrst,
  input wire logic                  i_output_disable_n,
  input wire logic                  i_input_present,
  input wire logic                  i_vco_fast_limit,
  input wire logic [3:0]            i_phase_too_short,
  input wire logic [3:0]            o_clk_run,
  input wire logic [3:0]            o_phase_step_apply,
  input wire cgpc_pkg::cgpc_phase_t o_phase0,
  input wire logic [2:0]            o_post_div_log2,
  input wire logic [3:0]            o_spread_on,
  input wire logic                  o_vco_cal_ctrl,
  input wire logic                  o_lock_signal_alarm
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // ==========================================
  // Spacing counter, saturates so idle never wraps
  logic [7:0] gap_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) gap_q <= 8'hff;
    else if (|o_phase_step_apply) gap_q <= 8'h00;
    else if (gap_q != 8'hff) gap_q <= gap_q + 8'h01;
  end
  // Outputs stay off for the stall, then come back
  sequence stall_seq;
    !o_clk_run[0] [*8] ##[1:4] o_clk_run[0];
  endsequence
  // ==========================================
  // Assertions
  step_spacing_a: assert property (|o_phase_step_apply |-> gap_q >= 8'h53)
    else $error("phase steps too close");
  disable_holds_a: assert property (i_output_disable_n [*4] |-> o_clk_run == 4'h0)
    else $error("outputs run while disabled");
  step_enable_a: assert property ((o_phase_step_apply & (o_spread_on | ~`CGPC_PH_EN)) == 4'h0)
    else $error("phase step on blocked channel");
  phase_range_a: assert property (o_phase0 <= 13'sh08ca && o_phase0 >= -13'sh08ca)
    else $error("phase out of range");
  phase_apply_a: assert property (!$stable(o_phase0) |-> o_phase_step_apply[0] && (o_phase0 == $past(o_phase0) + 13'sh0005 || o_phase0 == $past(o_phase0) - 13'sh0005 || o_phase0 == 13'sh08ca || o_phase0 == -13'sh08ca))
    else $error("phase moved off step");
  post_div_a: assert property (o_post_div_log2 <= 3'h5)
    else $error("post divider ratio out of set");
  spread_cfg_a: assert property ((o_spread_on & ~`CGPC_SS_EN) == 4'h0)
    else $error("spread on unconfigured output");
  loss_input_a: assert property (!i_input_present [*4] |-> o_lock_signal_alarm)
    else $error("alarm missing on lost input");
  cal_gate_a: assert property (o_vco_cal_ctrl |-> o_clk_run == 4'h0)
    else $error("outputs run during calibration");
  cal_mask_a: assert property ((o_vco_cal_ctrl && i_input_present) [*4] |-> !o_lock_signal_alarm)
    else $error("lock alarm not masked");
  stall_back_a: assert property ($fell(o_clk_run[0]) && (i_vco_fast_limit || |i_phase_too_short) |-> stall_seq)
    else $error("stall length wrong");
endmodule : cgpc_clock_gen_pin_control_asserts
bind cgpc_clock_gen_pin_control cgpc_clock_gen_pin_control_asserts u_chk (
  .i_mclk, .i_nrst, .i_output_disable_n, .i_input_present, .i_vco_fast_limit,
  .i_phase_too_short, .o_clk_run, .o_phase_step_apply, .o_phase0, .o_post_div_log2,
  .o_spread_on, .o_vco_cal_ctrl, .o_lock_signal_alarm
);
`default_nettype wire

/* tb/cgpc_host_model.sv */
// Board-side model driving the step pulse pins
`timescale 1ns/100ps
`default_nettype none
module cgpc_host_model (
  input  wire logic i_mclk,
  output var  logic o_step_up,
  output var  logic o_step_down
);
  // ==========================================
  // Pins idle low between requests
  initial begin
    o_step_up = 1'b0;
    o_step_down = 1'b0;
  end
  // One request, high then low in whole cycles
  task automatic pulse(input logic up, input int hi, input int lo);
    @(posedge i_mclk) #1;
    if (up) o_step_up = 1'b1;
    else o_step_down = 1'b1;
    repeat (hi) @(posedge i_mclk);
    #1 o_step_up = 1'b0;
    o_step_down = 1'b0;
    repeat (lo) @(posedge i_mclk);
    #1;
  endtask : pulse
endmodule : cgpc_host_model
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the clock control core
`include "cgpc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
  $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  typedef struct packed {logic up; logic [12:0] ph; logic [23:0] f;} cgpc_row_s;
  logic i_mclk = 1'b0, i_nrst = 1'b0, out_dis_n = 1'b0, ss_dis_n = 1'b1, in_ok = 1'b1;
  logic fast = 1'b0;
  logic [3:0] too_short = 4'h0, clk_run, apply, spread_on;
  logic [10:0] ppm = 11'h000;
  logic [23:0] freq0;
  logic [2:0] pdiv;
  logic cal, alarm, step_up, step_down;
  cgpc_pkg::cgpc_phase_t ph0, ph1, ph2, ph3;
  logic [23:0] ss_off, f_seen;
  int failures = 0, check_count = 0, cycle_count = 0;
  // Two up steps then three down steps, so both pins and both signs are seen
  cgpc_row_s rows [5] = '{'{1'b1, 13'h0005, 24'h100010}, '{1'b1, 13'h000a, 24'h100020},
    '{1'b0, 13'h0005, 24'h100010}, '{1'b0, 13'h0000, 24'h100000},
    '{1'b0, 13'h1ffb, 24'h0ffff0}};
  // ==========================================
  cgpc_clock_gen_pin_control uut (.i_mclk, .i_nrst, .i_output_disable_n(out_dis_n),
    .i_spread_disable_n(ss_dis_n), .i_step_up(step_up), .i_step_down(step_down),
    .i_input_present(in_ok), .i_pfd_ppm_diff(ppm), .i_vco_fast_limit(fast),
    .i_phase_too_short(too_short), .o_clk_run(clk_run), .o_phase_step_apply(apply),
    .o_phase0(ph0), .o_phase1(ph1), .o_phase2(ph2), .o_phase3(ph3), .o_freq0(freq0),
    .o_post_div_log2(pdiv), .o_spread_on(spread_on), .o_spread_offset(ss_off),
    .o_vco_cal_ctrl(cal), .o_lock_signal_alarm(alarm));
  cgpc_host_model host (.i_mclk, .o_step_up(step_up), .o_step_down(step_down));
  always #4 i_mclk = ~i_mclk;
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : cyc
  // Bounded wait, a hang shows up as a mismatch later
  task automatic wait_run(input logic v);
    for (int n = 0; n < 40 && clk_run[0] !== v; n++) cyc(1);
  endtask : wait_run
  task automatic complete_run();
    if (failures == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // Cycle ceiling well above the planned ~43k cycles
  always @(posedge i_mclk) begin
    cycle_count++;
    if (cycle_count == 60000) begin
      failures++;
      complete_run();
    end
  end
  // ==========================================
  initial begin
    cyc(5);
    i_nrst = 1'b1;
    cyc(3);
    `CHK("cal", 1'b1, cal)
    `CHK("run_cal", 4'h0, clk_run)
    for (int n = 0; n < 100 && cal !== 1'b0; n++) cyc(1);
    cyc(2);
    `CHK("run_up", `CGPC_OUT_EN, clk_run)
    `CHK("pdiv", 3'h0, pdiv)
    foreach (rows[i]) begin
      host.pulse(rows[i].up, 14, 100);
      `CHK("phase0", rows[i].ph, ph0)
      `CHK("phase1", rows[i].ph, ph1)
      `CHK("phase2", 13'h0000, ph2)
      `CHK("phase3", 13'h0000, ph3)
      `CHK("apply", 4'h0, apply)
      `CHK("freq0", rows[i].f, freq0)
    end
    repeat (460) host.pulse(1'b1, 14, 75);
    `CHK("phase_max", 13'h08ca, ph0)
    `CHK("freq_run", 24'h101cb0, freq0)
    host.pulse(1'b1, 10, 100);
    `CHK("short", 24'h101cb0, freq0)
    host.pulse(1'b0, 14, 14);
    host.pulse(1'b0, 14, 100);
    `CHK("close_ph", 13'h08c5, ph0)
    `CHK("close_f", 24'h101ca0, freq0)
    too_short = 4'h1;
    host.pulse(1'b0, 14, 14);
    wait_run(1'b0);
    `CHK("stall_ph", 1'b0, clk_run[0])
    wait_run(1'b1);
    `CHK("ph_kept", 13'h08c5, ph0)
    too_short = 4'h0;
    cyc(80);
    f_seen = freq0;
    fast = 1'b1;
    host.pulse(1'b1, 14, 14);
    wait_run(1'b0);
    `CHK("stall_f", 1'b0, clk_run[0])
    wait_run(1'b1);
    `CHK("resume", `CGPC_OUT_EN, clk_run)
    `CHK("f_kept", f_seen, freq0)
    fast = 1'b0;
    out_dis_n = 1'b1;
    cyc(5);
    `CHK("run_off", 4'h0, clk_run)
    `CHK("ss_off", 24'h000000, ss_off)
    out_dis_n = 1'b0;
    ss_dis_n = 1'b0;
    cyc(5);
    `CHK("run_on", `CGPC_OUT_EN, clk_run)
    `CHK("spread", 4'h0, spread_on)
    in_ok = 1'b0;
    cyc(5);
    `CHK("alarm_los", 1'b1, alarm)
    in_ok = 1'b1;
    cyc(5);
    `CHK("alarm_back", 1'b0, alarm)
    ppm = 11'h3e9;
    cyc(5);
    `CHK("alarm_lol", 1'b1, alarm)
    ppm = 11'h3e8;
    cyc(5);
    `CHK("alarm_edge", 1'b0, alarm)
    ppm = 11'h3e9;
    i_nrst = 1'b0;
    cyc(2);
    `CHK("rst_run", 4'h0, clk_run)
    i_nrst = 1'b1;
    cyc(3);
    `CHK("recal", 1'b1, cal)
    `CHK("lol_mask", 1'b0, alarm)
    complete_run();
  end
endmodule : testbench
`default_nettype wire
